// ### clmb_pkg.sv
// clmb_pkg: operation codes, status flag positions and cycle counts for the
// logic, multiply and program-flow execution block.
// assumes the decoder outside maps instruction words onto clmb_op_t codes.
package clmb_pkg;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_REG_DISJUNCTION       = 5'h00,
    OP_IMMEDIATE_DISJUNCTION = 5'h01,
    OP_EXCLUSIVE_DISJUNCTION = 5'h02,
    OP_BITWISE_INVERT        = 5'h03,
    OP_ARITHMETIC_INVERSION  = 5'h04,
    OP_MASK_SET_BITS         = 5'h05,
    OP_MASK_CLEAR_BITS       = 5'h06,
    OP_INCREMENT             = 5'h07,
    OP_DECREMENT             = 5'h08,
    OP_SELF_AND_TEST         = 5'h09,
    OP_PRODUCT_UNSIGNED      = 5'h0a,
    OP_PRODUCT_SIGNED        = 5'h0b,
    OP_PRODUCT_SIGNED_BY_U   = 5'h0c,
    OP_FRAC_PRODUCT_UNSIGNED = 5'h0d,
    OP_FRAC_PRODUCT_SIGNED   = 5'h0e,
    OP_FRAC_PRODUCT_MIXED    = 5'h0f,
    OP_RELATIVE_JUMP         = 5'h10,
    OP_POINTER_JUMP          = 5'h11,
    OP_ABSOLUTE_JUMP         = 5'h12,
    OP_RELATIVE_SUB_INVOKE   = 5'h13,
    OP_POINTER_SUB_INVOKE    = 5'h14,
    OP_ABSOLUTE_SUB_INVOKE   = 5'h15,
    OP_SUBROUTINE_EXIT       = 5'h16,
    OP_INTERRUPT_EXIT        = 5'h17,
    OP_COMPARE_SKIP_EQUAL    = 5'h18,
    OP_COMPARE               = 5'h19,
    OP_COMPARE_WITH_CARRY    = 5'h1a,
    OP_COMPARE_WITH_IMM      = 5'h1b,
    OP_SKIP_REG_BIT_ZERO     = 5'h1c,
    OP_SKIP_REG_BIT_ONE      = 5'h1d,
    OP_SKIP_IO_BIT_ZERO      = 5'h1e,
    OP_SKIP_IO_BIT_ONE       = 5'h1f
  } clmb_op_t;

  // ----------------------------------------------------------------
  // status flag positions and masks
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;
  localparam logic [7:0] MASK_NONE   = 8'h00;
  localparam logic [7:0] MASK_ZNV    = 8'h0e;
  localparam logic [7:0] MASK_ZCNV   = 8'h0f;
  localparam logic [7:0] MASK_ZCNVH  = 8'h2f;
  localparam logic [7:0] MASK_ZC     = 8'h03;
  localparam logic [7:0] MASK_I      = 8'h80;
  localparam logic [7:0] ALL_ONES    = 8'hff;

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_SINGLE   = 3'h1;
  localparam logic [2:0] CYC_PRODUCT  = 3'h2;
  localparam logic [2:0] CYC_REL_JUMP = 3'h2;
  localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
  localparam logic [2:0] CYC_ABS_JUMP = 3'h3;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_PTR_CALL = 3'h3;
  localparam logic [2:0] CYC_ABS_CALL = 3'h4;
  localparam logic [2:0] CYC_EXIT     = 3'h4;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

  // ----------------------------------------------------------------
  // program counter steps and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_STEP_ONE  = 16'h0001;
  localparam logic [15:0] PC_STEP_TWO  = 16'h0002;
  localparam logic [15:0] PC_STEP_SKIP = 16'h0002;
  localparam logic [15:0] PC_STEP_SKIP_LONG = 16'h0003;
  localparam logic [15:0] RESET_WORD   = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } clmb_state_t;

endpackage

// ### clmb_product.sv
// clmb_product: 8x8 multiplier with per-operand signedness and fractional shift.
// assumes operands are stable while the caller samples its outputs.
`timescale 1ns/1ns
`default_nettype none
module clmb_product
  import clmb_pkg::*;
(
  input  wire logic [7:0]  a,
  input  wire logic [7:0]  b,
  input  wire logic        a_signed,
  input  wire logic        b_signed,
  input  wire logic        fractional,
  output logic      [15:0] product,
  output logic             carry,
  output logic             zero
);
  // ----------------------------------------------------------------
  // nine-bit extension gives one signed path for all three sign mixes
  // ----------------------------------------------------------------
  wire logic signed [8:0]  ext_a = {a_signed & a[7], a};
  wire logic signed [8:0]  ext_b = {b_signed & b[7], b};
  wire logic signed [17:0] raw   = ext_a * ext_b;

  // carry is bit 15 of the unshifted product, lost by the fractional shift
  assign carry   = raw[15];                                   // RULE5
  assign product = fractional ? {raw[14:0], 1'b0} : raw[15:0]; // RULE6
  assign zero    = (product == 16'h0000);
endmodule
`default_nettype wire

// ### clmb_exec.sv
// clmb_exec: execution of logic, multiply, jump, call, return, compare and skip
// operations for an 8-bit core. assumes the decoder presents operands, the
// stack top and the selected i/o bit with START, and waits while BUSY is high.
// Summary of operation
// (RULE1) or of register with register or constant: write result, update Z N V, one cycle
// (RULE2) mask set bits forces ones where mask is one, updates Z N V, one cycle
// (RULE3) mask clear ands with 0xff minus mask, updates Z N V, one cycle
// (RULE4) self test ands register with itself, sets Z N V, one cycle
// (RULE5) integer multiplies write 16-bit product pair, update only Z C, two cycles
// (RULE6) fractional multiplies shift product left one, update Z C, two cycles
// (RULE7) pointer jump loads counter from pointer pair, no flags, two cycles
// (RULE8) pointer invoke saves return address, loads pointer, no flags, three cycles
// (RULE9) compare skip equal advances counter 2 or 3 on match, 1/2/3 cycles
// (RULE10) compares subtract without storing, update Z N V C H, one cycle
// (RULE11) skip when register bit zero, counter plus 2 or 3, 1 to 3 cycles
// (RULE12) skip when register bit one, 1/2/3 cycles, no flags
// (RULE13) skip when i/o bit zero, 1/2/3 cycles, no flags
// (RULE14) skip when i/o bit one, 1/2/3 cycles, no flags
// (RULE15) invert, negate, xor, increment, decrement give their results in one cycle
// (RULE16) relative jump two cycles to counter plus offset plus one; absolute three
// (RULE17) relative invoke three, absolute four; exits restore counter in four cycles
`timescale 1ns/1ns
`default_nettype none
module clmb_exec
  import clmb_pkg::*;
#(
  parameter int PC_WIDTH = 16
)
(
  input  wire logic                CLOCK,
  input  wire logic                RESET_N,
  input  wire logic                START,
  input  wire clmb_op_t            OP,
  input  wire logic [7:0]          RD_VALUE,
  input  wire logic [7:0]          SOURCE_REGISTER,
  input  wire logic [7:0]          FLAGS_IN,
  input  wire logic [PC_WIDTH-1:0] PROGRAM_COUNTER,
  input  wire logic [PC_WIDTH-1:0] POINTER_Z,
  input  wire logic [11:0]         OFFSET,
  input  wire logic [PC_WIDTH-1:0] TARGET,
  input  wire logic [PC_WIDTH-1:0] STACK_TOP,
  input  wire logic [2:0]          BIT_SEL,
  input  wire logic                IO_BIT,
  input  wire logic                NEXT_TWO_WORD,
  output logic      [7:0]          RESULT,
  output logic                     RESULT_WE,
  output logic      [15:0]         PRODUCT_REGISTER_PAIR,
  output logic                     PRODUCT_WE,
  output logic      [7:0]          FLAGS_OUT,
  output logic      [7:0]          FLAGS_WE_MASK,
  output logic      [PC_WIDTH-1:0] NEXT_PC,
  output logic                     PC_LOAD,
  output logic      [PC_WIDTH-1:0] PUSH_ADDR,
  output logic                     PUSH_REQ,
  output logic                     POP_REQ,
  output logic                     BUSY,
  output logic                     DONE
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic take = START & ~BUSY;
  wire logic is_or  = (OP == OP_REG_DISJUNCTION) | (OP == OP_IMMEDIATE_DISJUNCTION)
                    | (OP == OP_MASK_SET_BITS);
  wire logic is_mul = (OP >= OP_PRODUCT_UNSIGNED) & (OP <= OP_FRAC_PRODUCT_MIXED);
  wire logic is_cmp = (OP == OP_COMPARE) | (OP == OP_COMPARE_WITH_CARRY)
                    | (OP == OP_COMPARE_WITH_IMM);
  wire logic is_neg = (OP == OP_ARITHMETIC_INVERSION);
  wire logic is_skip = (OP == OP_COMPARE_SKIP_EQUAL) | (OP >= OP_SKIP_REG_BIT_ZERO);
  wire logic is_call = (OP == OP_RELATIVE_SUB_INVOKE) | (OP == OP_POINTER_SUB_INVOKE)
                     | (OP == OP_ABSOLUTE_SUB_INVOKE);
  wire logic is_exit = (OP == OP_SUBROUTINE_EXIT) | (OP == OP_INTERRUPT_EXIT);
  wire logic is_pc   = (OP >= OP_RELATIVE_JUMP) & (OP <= OP_INTERRUPT_EXIT);

  // ----------------------------------------------------------------
  // subtract path, shared by compares and arithmetic inversion
  // ----------------------------------------------------------------
  wire logic [7:0] sub_a   = is_neg ? 8'h00 : RD_VALUE;
  wire logic [7:0] sub_b   = is_neg ? RD_VALUE : SOURCE_REGISTER;
  wire logic       sub_cin = (OP == OP_COMPARE_WITH_CARRY) & FLAGS_IN[FLAG_C];
  wire logic [8:0] sub_raw = {1'b0, sub_a} - {1'b0, sub_b} - {8'h00, sub_cin};
  wire logic [7:0] sub_r   = sub_raw[7:0];
  wire logic       sub_h   = (~sub_a[3] & sub_b[3]) | (sub_b[3] & sub_r[3])
                           | (sub_r[3] & ~sub_a[3]);
  wire logic       sub_v   = (sub_a[7] & ~sub_b[7] & ~sub_r[7])
                           | (~sub_a[7] & sub_b[7] & sub_r[7]);
  // compare with carry keeps zero only if it was already set
  wire logic       sub_z   = (sub_r == 8'h00)
                           & ((OP != OP_COMPARE_WITH_CARRY) | FLAGS_IN[FLAG_Z]);

  // ----------------------------------------------------------------
  // byte results
  // ----------------------------------------------------------------
  logic [7:0] logic_r;
  always_comb begin
    unique case (OP)
      OP_REG_DISJUNCTION, OP_IMMEDIATE_DISJUNCTION,
      OP_MASK_SET_BITS:         logic_r = RD_VALUE | SOURCE_REGISTER;            // RULE1 RULE2
      OP_MASK_CLEAR_BITS:       logic_r = RD_VALUE & (ALL_ONES - SOURCE_REGISTER); // RULE3
      OP_SELF_AND_TEST:         logic_r = RD_VALUE & RD_VALUE;                   // RULE4
      OP_EXCLUSIVE_DISJUNCTION: logic_r = RD_VALUE ^ SOURCE_REGISTER;            // RULE15
      OP_BITWISE_INVERT:        logic_r = ALL_ONES - RD_VALUE;                   // RULE15
      OP_INCREMENT:             logic_r = RD_VALUE + 8'h01;                      // RULE15
      OP_DECREMENT:             logic_r = RD_VALUE - 8'h01;                      // RULE15
      default:                  logic_r = sub_r;
    endcase
  end

  wire logic byte_op = (OP <= OP_SELF_AND_TEST);
  wire logic v_incdec = ((OP == OP_INCREMENT) & (logic_r == 8'h80))
                      | ((OP == OP_DECREMENT) & (logic_r == 8'h7f));

  logic [15:0] mul_p;
  logic        mul_carry;
  logic        mul_zero;
  logic [7:0]  flag_val;
  logic [7:0]  flag_mask;
  always_comb begin
    flag_val  = 8'h00;
    flag_mask = MASK_NONE;
    if (is_cmp | is_neg) begin
      flag_val[FLAG_C] = sub_raw[8];                                            // RULE10
      flag_val[FLAG_Z] = is_neg ? (sub_r == 8'h00) : sub_z;
      flag_val[FLAG_N] = sub_r[7];
      flag_val[FLAG_V] = sub_v;
      flag_val[FLAG_H] = sub_h;
      flag_mask        = MASK_ZCNVH;
    end else if (byte_op) begin
      flag_val[FLAG_Z] = (logic_r == 8'h00);                                    // RULE1 RULE4
      flag_val[FLAG_N] = logic_r[7];
      flag_val[FLAG_V] = v_incdec;
      flag_val[FLAG_C] = (OP == OP_BITWISE_INVERT);
      flag_mask        = (OP == OP_BITWISE_INVERT) ? MASK_ZCNV : MASK_ZNV;
    end else if (is_mul) begin
      flag_val[FLAG_Z] = mul_zero;                                              // RULE5
      flag_val[FLAG_C] = mul_carry;
      flag_mask        = MASK_ZC;
    end else if (OP == OP_INTERRUPT_EXIT) begin
      flag_val[FLAG_I] = 1'b1;
      flag_mask        = MASK_I;
    end
  end

  // ----------------------------------------------------------------
  // multiplier
  // ----------------------------------------------------------------
  wire logic   mul_sa = (OP == OP_PRODUCT_SIGNED) | (OP == OP_PRODUCT_SIGNED_BY_U)
                      | (OP == OP_FRAC_PRODUCT_SIGNED) | (OP == OP_FRAC_PRODUCT_MIXED);
  wire logic   mul_sb = (OP == OP_PRODUCT_SIGNED) | (OP == OP_FRAC_PRODUCT_SIGNED);
  wire logic   mul_fr = (OP >= OP_FRAC_PRODUCT_UNSIGNED);

  clmb_product u_product (
    .a          (RD_VALUE),
    .b          (SOURCE_REGISTER),
    .a_signed   (mul_sa),
    .b_signed   (mul_sb),
    .fractional (mul_fr),
    .product    (mul_p),
    .carry      (mul_carry),
    .zero       (mul_zero)
  );

  // ----------------------------------------------------------------
  // program counter and skip decisions
  // ----------------------------------------------------------------
  wire logic [PC_WIDTH-1:0] rel_target = PROGRAM_COUNTER
                                       + {{(PC_WIDTH-12){OFFSET[11]}}, OFFSET}
                                       + PC_STEP_ONE[PC_WIDTH-1:0];
  logic skip_cond;
  always_comb begin
    unique case (OP)
      OP_COMPARE_SKIP_EQUAL: skip_cond = (RD_VALUE == SOURCE_REGISTER); // RULE9
      OP_SKIP_REG_BIT_ZERO:  skip_cond = ~SOURCE_REGISTER[BIT_SEL];     // RULE11
      OP_SKIP_REG_BIT_ONE:   skip_cond = SOURCE_REGISTER[BIT_SEL];      // RULE12
      OP_SKIP_IO_BIT_ZERO:   skip_cond = ~IO_BIT;                       // RULE13
      OP_SKIP_IO_BIT_ONE:    skip_cond = IO_BIT;                        // RULE14
      default:               skip_cond = 1'b0;
    endcase
  end
  wire logic [PC_WIDTH-1:0] skip_step = !skip_cond ? PC_STEP_ONE[PC_WIDTH-1:0]
                                      : NEXT_TWO_WORD ? PC_STEP_SKIP_LONG[PC_WIDTH-1:0]
                                      : PC_STEP_SKIP[PC_WIDTH-1:0];

  logic [PC_WIDTH-1:0] pc_target;
  logic [2:0]          cycles;
  always_comb begin
    pc_target = PROGRAM_COUNTER + skip_step;
    cycles    = CYC_SINGLE;
    unique case (OP)
      OP_RELATIVE_JUMP:       begin pc_target = rel_target; cycles = CYC_REL_JUMP; end // RULE16
      OP_ABSOLUTE_JUMP:       begin pc_target = TARGET;     cycles = CYC_ABS_JUMP; end // RULE16
      OP_POINTER_JUMP:        begin pc_target = POINTER_Z;  cycles = CYC_PTR_JUMP; end // RULE7
      OP_POINTER_SUB_INVOKE:  begin pc_target = POINTER_Z;  cycles = CYC_PTR_CALL; end // RULE8
      OP_RELATIVE_SUB_INVOKE: begin pc_target = rel_target; cycles = CYC_REL_CALL; end // RULE17
      OP_ABSOLUTE_SUB_INVOKE: begin pc_target = TARGET;     cycles = CYC_ABS_CALL; end // RULE17
      OP_SUBROUTINE_EXIT,
      OP_INTERRUPT_EXIT:      begin pc_target = STACK_TOP;  cycles = CYC_EXIT;     end // RULE17
      default: begin
        if (is_mul) begin
          cycles = CYC_PRODUCT;                                                      // RULE5 RULE6
        end else if (is_skip & skip_cond) begin
          cycles = NEXT_TWO_WORD ? CYC_SKIP_TWO : CYC_SKIP_ONE;                      // RULE9
        end
      end
    endcase
  end

  // absolute invoke is two words long, the others one
  wire logic [PC_WIDTH-1:0] ret_addr = PROGRAM_COUNTER
      + ((OP == OP_ABSOLUTE_SUB_INVOKE) ? PC_STEP_TWO[PC_WIDTH-1:0]
                                         : PC_STEP_ONE[PC_WIDTH-1:0]);

  // strobes held back until the last cycle: {result, product, pc, push, pop}
  wire logic [4:0] next_pend = {byte_op, is_mul, is_pc | is_skip, is_call, is_exit};

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  clmb_state_t state;
  logic [1:0]  cnt;
  logic [4:0]  pend;
  wire logic   finish_now = take & (cycles == CYC_SINGLE);
  wire logic   finish_wait = (state == ST_WAIT) & (cnt == 2'h0);
  wire logic   finish = finish_now | finish_wait;
  wire logic [4:0] fire = finish_now ? next_pend : pend;

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      cnt   <= 2'h0;
      pend  <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take & !finish_now) begin
            state <= ST_WAIT;
            cnt   <= 2'(cycles - 3'h2);
            pend  <= next_pend;
          end
        end
        ST_WAIT: begin
          if (cnt == 2'h0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 2'h1;
          end
        end
      endcase
    end
  end

  // data outputs are loaded at acceptance and held until the next one
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      RESULT                <= 8'h00;
      PRODUCT_REGISTER_PAIR <= RESET_WORD;
      FLAGS_OUT             <= 8'h00;
      FLAGS_WE_MASK         <= MASK_NONE;
      NEXT_PC               <= RESET_WORD[PC_WIDTH-1:0];
      PUSH_ADDR             <= RESET_WORD[PC_WIDTH-1:0];
    end else if (take) begin
      RESULT                <= logic_r;
      PRODUCT_REGISTER_PAIR <= mul_p;                                            // RULE5
      FLAGS_OUT             <= flag_val;
      FLAGS_WE_MASK         <= flag_mask;
      NEXT_PC               <= pc_target;
      PUSH_ADDR             <= ret_addr;                                         // RULE8
    end
  end

  // compares and skips never write a register
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      {RESULT_WE, PRODUCT_WE, PC_LOAD, PUSH_REQ, POP_REQ} <= 5'h00;
      DONE <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      {RESULT_WE, PRODUCT_WE, PC_LOAD, PUSH_REQ, POP_REQ} <= finish ? fire : 5'h00;
      DONE <= finish;
      BUSY <= (take & !finish_now) | ((state == ST_WAIT) & (cnt != 2'h0));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OR_ONE_CYCLE: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE1
    take && OP == OP_REG_DISJUNCTION |=> DONE && RESULT_WE
      && RESULT == ($past(RD_VALUE) | $past(SOURCE_REGISTER)) && FLAGS_WE_MASK == MASK_ZNV)
    else $error("or result or timing wrong");
  AST_MASK_SET: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE2
    take && OP == OP_MASK_SET_BITS |=> DONE && ((RESULT & $past(SOURCE_REGISTER))
      == $past(SOURCE_REGISTER)))
    else $error("mask set left a bit clear");
  AST_MASK_CLEAR: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE3
    take && OP == OP_MASK_CLEAR_BITS |=> DONE && (RESULT & $past(SOURCE_REGISTER)) == 8'h00)
    else $error("mask clear left a bit set");
  AST_SELF_TEST: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE4
    take && OP == OP_SELF_AND_TEST |=> RESULT == $past(RD_VALUE)
      && FLAGS_OUT[FLAG_Z] == ($past(RD_VALUE) == 8'h00) && FLAGS_OUT[FLAG_N] == RESULT[7])
    else $error("self test flags wrong");
  AST_PRODUCT_TWO: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE5
    take && OP == OP_PRODUCT_UNSIGNED |=> !DONE ##1 DONE && PRODUCT_WE
      && PRODUCT_REGISTER_PAIR == 16'($past(RD_VALUE, 2) * $past(SOURCE_REGISTER, 2))
      && FLAGS_WE_MASK == MASK_ZC)
    else $error("unsigned product wrong");
  AST_FRAC_SHIFT: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE6
    take && OP == OP_FRAC_PRODUCT_UNSIGNED |=> !DONE ##1 DONE
      && PRODUCT_REGISTER_PAIR == 16'(($past(RD_VALUE, 2) * $past(SOURCE_REGISTER, 2)) << 1))
    else $error("fractional product not shifted");
  AST_PTR_JUMP: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE7
    take && OP == OP_POINTER_JUMP |=> !PC_LOAD ##1 PC_LOAD && NEXT_PC == $past(POINTER_Z, 2)
      && FLAGS_WE_MASK == MASK_NONE)
    else $error("pointer jump wrong");
  AST_PTR_CALL: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE8
    take && OP == OP_POINTER_SUB_INVOKE |=> !DONE [*2] ##1 DONE && PUSH_REQ
      && PUSH_ADDR == $past(PROGRAM_COUNTER, 3) + 16'h0001)
    else $error("pointer invoke wrong");
  AST_SKIP_EQUAL: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE9
    take && OP == OP_COMPARE_SKIP_EQUAL && RD_VALUE == SOURCE_REGISTER && !NEXT_TWO_WORD
      |=> !DONE ##1 DONE && NEXT_PC == $past(PROGRAM_COUNTER, 2) + 16'h0002)
    else $error("equal skip wrong");
  AST_COMPARE: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE10
    take && OP == OP_COMPARE |=> DONE && !RESULT_WE && FLAGS_WE_MASK == MASK_ZCNVH
      && FLAGS_OUT[FLAG_C] == ($past(RD_VALUE) < $past(SOURCE_REGISTER)))
    else $error("compare flags wrong");
  AST_SKIP_BIT: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE11
    take && OP == OP_SKIP_REG_BIT_ZERO && SOURCE_REGISTER[BIT_SEL] |=> DONE
      && NEXT_PC == $past(PROGRAM_COUNTER) + 16'h0001)
    else $error("bit skip taken on one");
  AST_EXIT_FOUR: assert property (@(posedge CLOCK) disable iff (!RESET_N) // RULE17
    take && OP == OP_SUBROUTINE_EXIT |=> BUSY [*3] ##1 DONE && POP_REQ)
    else $error("exit not four cycles");
endmodule
`default_nettype wire

// ### clmb_partner.sv
// clmb_partner: stack side of the execution block, keeps pushed return words.
// assumes one push or pop per strobe and at most seven nested invokes.
`timescale 1ns/1ns
`default_nettype none
module clmb_partner (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PUSH_REQ,
  input  wire logic [15:0] PUSH_ADDR,
  input  wire logic        POP_REQ,
  output logic      [15:0] STACK_TOP
);
  logic [15:0] mem [8];
  logic [2:0]  sp;
  logic [15:0] last;
  // an empty stack shows the inverse of the last word, so a stale read is caught
  assign STACK_TOP = (sp != 3'h0) ? mem[sp - 3'h1] : ~last;
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      sp   <= 3'h0;
      last <= 16'h0000;
    end else if (PUSH_REQ) begin
      mem[sp] <= PUSH_ADDR;
      sp      <= sp + 3'h1;
    end else if (POP_REQ && sp != 3'h0) begin
      last <= mem[sp - 3'h1];
      sp   <= sp - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ### core_logic_mul_branch_exec_tb_top.sv
// core_logic_mul_branch_exec_tb_top: table-driven bench for clmb_exec.
// assumes a 25 MHz clock and the stack model clmb_partner on the far side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module core_logic_mul_branch_exec_tb_top import clmb_pkg::*;;
  typedef struct packed {
    clmb_op_t op; logic [7:0] rd, rr; logic [2:0] n; logic [15:0] exp; logic [7:0] msk;
  } clmb_row_t;
  clmb_row_t   rows[$];
  logic        CLOCK = 1'b0, RESET_N = 1'b0, START = 1'b0, IO_BIT = 1'b0, NEXT_TWO_WORD = 1'b0;
  clmb_op_t    OP = OP_REG_DISJUNCTION;
  logic [7:0]  RD_VALUE = 8'h00, SOURCE_REGISTER = 8'h00, FLAGS_IN = 8'h00;
  logic [2:0]  BIT_SEL = 3'h3;
  logic [11:0] OFFSET = 12'h010;
  logic [15:0] PROGRAM_COUNTER = 16'h0100, POINTER_Z = 16'h2345, TARGET = 16'h4000;
  logic [7:0]  RESULT, FLAGS_OUT, FLAGS_WE_MASK;
  logic        RESULT_WE, PRODUCT_WE, PC_LOAD, PUSH_REQ, POP_REQ, BUSY, DONE;
  logic [15:0] PRODUCT_REGISTER_PAIR, NEXT_PC, PUSH_ADDR, STACK_TOP;
  int          failures = 0, cmp_count = 0, k;
  clmb_exec DUT (.*);
  clmb_partner PARTNER (.*);
  always #20 CLOCK = ~CLOCK;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic add(input clmb_op_t o, input logic [7:0] d, r, input logic [2:0] n,
                     input logic [15:0] e, input logic [7:0] m);
    rows.push_back('{o, d, r, n, e, m});
  endtask
  // one idle cycle first, so START is never lowered and raised in one step
  task automatic run(input clmb_op_t o, input logic [7:0] d, r, output int c);
    @(posedge CLOCK); #1;
    OP = o; RD_VALUE = d; SOURCE_REGISTER = r; IO_BIT = d[3]; START = 1'b1;
    @(posedge CLOCK); #1;
    START = 1'b0;
    c = 1;
    while (DONE !== 1'b1 && c < 8) begin
      @(posedge CLOCK); #1;
      c++;
    end
  endtask
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin #100000; failures++; close_out; end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    add(OP_REG_DISJUNCTION, 8'h50, 8'h0a, 3'h1, 16'h005a, MASK_ZNV);
    add(OP_IMMEDIATE_DISJUNCTION, 8'h80, 8'h01, 3'h1, 16'h0081, MASK_ZNV);
    add(OP_EXCLUSIVE_DISJUNCTION, 8'hff, 8'h0f, 3'h1, 16'h00f0, MASK_ZNV);
    add(OP_BITWISE_INVERT, 8'h3c, 8'h00, 3'h1, 16'h00c3, MASK_ZCNV);
    add(OP_ARITHMETIC_INVERSION, 8'h01, 8'h00, 3'h1, 16'h00ff, MASK_ZCNVH);
    add(OP_MASK_SET_BITS, 8'h10, 8'h03, 3'h1, 16'h0013, MASK_ZNV);
    add(OP_MASK_CLEAR_BITS, 8'hff, 8'h0f, 3'h1, 16'h00f0, MASK_ZNV);
    add(OP_INCREMENT, 8'h7f, 8'h00, 3'h1, 16'h0080, MASK_ZNV);
    add(OP_DECREMENT, 8'h00, 8'h00, 3'h1, 16'h00ff, MASK_ZNV);
    add(OP_SELF_AND_TEST, 8'h00, 8'h00, 3'h1, 16'h0000, MASK_ZNV);
    add(OP_PRODUCT_UNSIGNED, 8'hff, 8'hff, 3'h2, 16'hfe01, MASK_ZC);
    add(OP_PRODUCT_SIGNED, 8'hff, 8'h02, 3'h2, 16'hfffe, MASK_ZC);
    add(OP_PRODUCT_SIGNED_BY_U, 8'hff, 8'h02, 3'h2, 16'hfffe, MASK_ZC);
    add(OP_FRAC_PRODUCT_UNSIGNED, 8'h80, 8'h80, 3'h2, 16'h8000, MASK_ZC);
    add(OP_FRAC_PRODUCT_SIGNED, 8'hc0, 8'h40, 3'h2, 16'he000, MASK_ZC);
    add(OP_FRAC_PRODUCT_MIXED, 8'hc0, 8'h40, 3'h2, 16'he000, MASK_ZC);
    add(OP_RELATIVE_JUMP, 8'h00, 8'h00, 3'h2, 16'h0111, MASK_NONE);
    add(OP_POINTER_JUMP, 8'h00, 8'h00, 3'h2, 16'h2345, MASK_NONE);
    add(OP_ABSOLUTE_JUMP, 8'h00, 8'h00, 3'h3, 16'h4000, MASK_NONE);
    add(OP_RELATIVE_SUB_INVOKE, 8'h00, 8'h00, 3'h3, 16'h0111, MASK_NONE);
    add(OP_POINTER_SUB_INVOKE, 8'h00, 8'h00, 3'h3, 16'h2345, MASK_NONE);
    add(OP_ABSOLUTE_SUB_INVOKE, 8'h00, 8'h00, 3'h4, 16'h4000, MASK_NONE);
    add(OP_SUBROUTINE_EXIT, 8'h00, 8'h00, 3'h4, 16'h0102, MASK_NONE);
    add(OP_INTERRUPT_EXIT, 8'h00, 8'h00, 3'h4, 16'h0101, MASK_I);
    add(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h33, 3'h2, 16'h0102, MASK_NONE);
    add(OP_COMPARE_SKIP_EQUAL, 8'h33, 8'h34, 3'h1, 16'h0101, MASK_NONE);
    add(OP_SKIP_REG_BIT_ZERO, 8'h00, 8'h00, 3'h2, 16'h0102, MASK_NONE);
    add(OP_SKIP_REG_BIT_ZERO, 8'h08, 8'h08, 3'h1, 16'h0101, MASK_NONE);
    add(OP_SKIP_REG_BIT_ONE, 8'h00, 8'h00, 3'h1, 16'h0101, MASK_NONE);
    add(OP_SKIP_IO_BIT_ZERO, 8'h08, 8'h08, 3'h1, 16'h0101, MASK_NONE);
    add(OP_SKIP_IO_BIT_ONE, 8'h08, 8'h08, 3'h2, 16'h0102, MASK_NONE);
    repeat (3) @(posedge CLOCK);
    #1 RESET_N = 1'b1;
    `CHK({BUSY, DONE, PC_LOAD, NEXT_PC}, 19'h00000) // RESET
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].rd, rows[i].rr, k);
      `CHK(k, int'(rows[i].n))
      `CHK(FLAGS_WE_MASK, rows[i].msk)
      if (rows[i].op <= OP_SELF_AND_TEST) `CHK({8'h00, RESULT}, rows[i].exp)
      else if (rows[i].op <= OP_FRAC_PRODUCT_MIXED) `CHK(PRODUCT_REGISTER_PAIR, rows[i].exp)
      else `CHK(NEXT_PC, rows[i].exp)
    end
    // compares keep the register untouched; carry-in with a zero result keeps Z
    FLAGS_IN = 8'h03;
    run(OP_COMPARE, 8'h10, 8'h20, k);
    `CHK({RESULT_WE, FLAGS_OUT & MASK_ZCNVH, FLAGS_WE_MASK}, {1'b0, 8'h05, MASK_ZCNVH})
    run(OP_COMPARE_WITH_CARRY, 8'h20, 8'h1f, k);
    `CHK({RESULT_WE, FLAGS_OUT & MASK_ZCNVH, 3'(k)}, {1'b0, 8'h22, 3'h1})
    run(OP_COMPARE_WITH_IMM, 8'h20, 8'h20, k);
    `CHK({RESULT_WE, FLAGS_OUT & MASK_ZCNVH, 3'(k)}, {1'b0, 8'h02, 3'h1})
    NEXT_TWO_WORD = 1'b1;
    run(OP_COMPARE_SKIP_EQUAL, 8'h44, 8'h44, k);
    `CHK({NEXT_PC, 3'(k)}, {16'h0103, 3'h3})
    run(OP_SKIP_REG_BIT_ONE, 8'h08, 8'h08, k);
    `CHK({NEXT_PC, 3'(k)}, {16'h0103, 3'h3})
    // back to back: START held over two single-cycle operations
    OP = OP_REG_DISJUNCTION; RD_VALUE = 8'h01; SOURCE_REGISTER = 8'h02; START = 1'b1;
    @(posedge CLOCK); #1;
    `CHK({DONE, RESULT}, {1'b1, 8'h03})
    OP = OP_MASK_CLEAR_BITS; RD_VALUE = 8'h3c;
    @(posedge CLOCK); #1;
    START = 1'b0;
    `CHK({DONE, RESULT}, {1'b1, 8'h3c & (8'hff - 8'h02)})
    // reset in mid-operation drops BUSY at the next clock edge
    run(OP_ABSOLUTE_JUMP, 8'h00, 8'h00, k);
    START = 1'b1;
    @(posedge CLOCK); #1;
    START = 1'b0; RESET_N = 1'b0;
    @(posedge CLOCK); #1;
    `CHK({BUSY, DONE}, 2'b00) // RESET
    RESET_N = 1'b1;
    close_out;
  end
endmodule
`default_nettype wire
